// file: bst_pkg.sv
// shared constants, types and helpers of the boundary scan test unit
package bst_pkg;

    // ********************************************************
    // sizes
    // ********************************************************
    localparam int NUM_PINS = 124;
    localparam int NUM_CELLS = 344;
    localparam int IR_W = 3;
    localparam int ID_W = 32;

    // set where a scan position is a one-cell input; index is position-1
    localparam logic [NUM_PINS-1:0] IN_ONLY_MASK =
        (124'h1 << 16) | (124'h1 << 17) | (124'h1 << 86) |
        (124'h1 << 92) | (124'h1 << 93) | (124'h1 << 97) |
        (124'h1 << 106) | (124'h1 << 107) | (124'h1 << 116) |
        (124'h1 << 117) | (124'h1 << 120) | (124'h1 << 121) |
        (124'h1 << 122) | (124'h1 << 123);
    localparam int IN_CELLS = 1;
    localparam int IO_CELLS = 3;
    localparam int CELL_OUT_OFS = 1;
    localparam int CELL_OE_OFS = 2;

    // ********************************************************
    // reset and load values
    // ********************************************************
    localparam logic CELL_RST = 1'b0;
    localparam logic ID_LSB = 1'b1;
    localparam logic BYP_CAPTURE = 1'b0;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [2:0] {
        BST_EXTEST = 3'h0,
        BST_INTEST = 3'h1,
        BST_SAMPLE = 3'h2,
        BST_IDCODE = 3'h3,
        BST_BYPASS = 3'h7
    } bst_instr_e;

    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
    localparam logic [IR_W-1:0] IR_RESET_VAL = 3'h3;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6,
        ST_EX2_DR = 4'h7, ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb, ST_EX1_IR = 4'hc,
        ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
    } bst_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_tap_s;

    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } bst_drive_s;

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic int cell_base(input int pos);
        int acc;
        acc = 0;
        for (int p = 0; p < pos; p++) begin
            acc += IN_ONLY_MASK[p] ? IN_CELLS : IO_CELLS;
        end
        return acc;
    endfunction

    // unknown codes fall back to the bypass path
    function automatic bst_instr_e decode_ir(input logic [IR_W-1:0] ir);
        case (ir)
            3'h0: return BST_EXTEST;
            3'h1: return BST_INTEST;
            3'h2: return BST_SAMPLE;
            3'h3: return BST_IDCODE;
            default: return BST_BYPASS;
        endcase
    endfunction

endpackage

// file: bst_tap_fsm.sv
// sixteen-state test port sequencer, advanced once per test clock rise
`timescale 1ns/1ps
module bst_tap_fsm (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // test clock rise and mode select
    input wire logic i_step,
    input wire logic i_tms,
    // state
    output bst_pkg::bst_state_e o_state
);
    import bst_pkg::*;

    bst_state_e state_q;
    bst_state_e state_d;

    always_comb begin
        state_d = state_q;
        if (i_step) begin
            case (state_q)
                ST_RESET: state_d = i_tms ? ST_RESET : ST_IDLE;
                ST_IDLE: state_d = i_tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: state_d = i_tms ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: state_d = i_tms ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR: state_d = i_tms ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: state_d = i_tms ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: state_d = i_tms ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: state_d = i_tms ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: state_d = i_tms ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: state_d = i_tms ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: state_d = i_tms ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR: state_d = i_tms ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: state_d = i_tms ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: state_d = i_tms ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: state_d = i_tms ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: state_d = i_tms ? ST_SEL_DR : ST_IDLE;
                default: state_d = ST_RESET;
            endcase
        end
    end

    // power-on reset lands the sequencer in test-logic-reset
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_state = state_q;

endmodule

// file: bst_tap_unit.sv
// boundary scan test access unit: scan chain, instruction and id paths
`timescale 1ns/1ps
// What this block does
// - input one cell, output three, bidirectional three
// - some single-direction pins use three cells
// - boundary register is exactly 344 cells
// - all boundary cells start at zero
// - positions rise toward output; last is input
// - decode five codes; others act as bypass
// - extest captures pads, drives outputs from cells
// - extest shifts, updates outputs, then recaptures
// - intest captures core outputs, cells feed core
// - intest shifts, then updates cells driving core
// - capture-IR loads code 001
// - sample snapshots pins without disturbing function
// - idcode shifts 32-bit word, LSB one
// - test-logic-reset loads code 011
// - bypass delays data by one test clock
// - power-on reset resets the state machine
module bst_tap_unit #(
    parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] ID_DEVICE = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h055 // arbitrary value
) (
    // clock and power-on reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // serial test port
    input wire bst_pkg::bst_tap_s i_tap,
    output logic o_tdo,
    output logic o_tdo_oe,
    // pad side
    input wire logic [bst_pkg::NUM_PINS-1:0] i_pad_in,
    output bst_pkg::bst_drive_s o_pad,
    // core side
    input wire bst_pkg::bst_drive_s i_core,
    output logic [bst_pkg::NUM_PINS-1:0] o_core_in
);
    import bst_pkg::*;

    // ********************************************************
    // pin synchronisers and test clock edges
    // ********************************************************
    bst_tap_s tap_s1_q;
    bst_tap_s tap_s2_q;
    logic tck_last_q;
    logic [NUM_PINS-1:0] pad_s1_q;
    logic [NUM_PINS-1:0] pad_s2_q;
    logic tck_rise;
    logic tck_fall;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            tap_s1_q <= '0;
            tap_s2_q <= '0;
            tck_last_q <= 1'b0;
            pad_s1_q <= '0;
            pad_s2_q <= '0;
        end else begin
            tap_s1_q <= i_tap;
            tap_s2_q <= tap_s1_q;
            tck_last_q <= tap_s2_q.tck;
            pad_s1_q <= i_pad_in;
            pad_s2_q <= pad_s1_q;
        end
    end

    // the test clock is 8 system clocks, so edges are found reliably
    assign tck_rise = tap_s2_q.tck & ~tck_last_q;
    assign tck_fall = ~tap_s2_q.tck & tck_last_q;

    bst_state_e state;

    bst_tap_fsm u_fsm (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_step(tck_rise),
        .i_tms(tap_s2_q.tms),
        .o_state(state)
    );

    // ********************************************************
    // instruction path
    // ********************************************************
    logic [IR_W-1:0] irsh_q;
    logic [IR_W-1:0] irsh_d;
    logic [IR_W-1:0] ir_q;
    logic [IR_W-1:0] ir_d;
    bst_instr_e mode;

    always_comb begin
        irsh_d = irsh_q;
        ir_d = ir_q;
        if (state == ST_RESET) begin
            ir_d = IR_RESET_VAL;
        end
        if (tck_rise && state == ST_CAP_IR) begin
            irsh_d = IR_CAPTURE_VAL;
        end else if (tck_rise && state == ST_SH_IR) begin
            irsh_d = {tap_s2_q.tdi, irsh_q[IR_W-1:1]};
        end
        if (tck_fall && state == ST_UPD_IR) begin
            ir_d = irsh_q;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            irsh_q <= IR_RESET_VAL;
            ir_q <= IR_RESET_VAL;
        end else begin
            irsh_q <= irsh_d;
            ir_q <= ir_d;
        end
    end

    assign mode = decode_ir(ir_q);

    // ********************************************************
    // boundary cells: capture values and pin drive
    // ********************************************************
    logic [NUM_CELLS-1:0] cap_val;
    logic [NUM_CELLS-1:0] chain_q;
    logic [NUM_CELLS-1:0] chain_d;
    logic [NUM_CELLS-1:0] upd_q;
    logic [NUM_CELLS-1:0] upd_d;
    logic intest;
    logic extest;

    assign intest = (mode == BST_INTEST);
    assign extest = (mode == BST_EXTEST);

    // cell 0 sits next to the serial input, the last next to the output
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        localparam int B = cell_base(p);
        if (IN_ONLY_MASK[p]) begin : g_in
            // intest keeps the held value instead of the live pad
            assign cap_val[B] = intest ? upd_q[B] : pad_s2_q[p];
            assign o_core_in[p] = intest ? upd_q[B] : i_pad_in[p];
            assign o_pad.out[p] = 1'b0;
            assign o_pad.oe[p] = 1'b0;
        end else begin : g_io
            // single-direction pins of this group still get three cells
            assign cap_val[B] = intest ? upd_q[B] : pad_s2_q[p];
            assign cap_val[B+CELL_OUT_OFS] = i_core.out[p];
            assign cap_val[B+CELL_OE_OFS] = i_core.oe[p];
            assign o_core_in[p] = intest ? upd_q[B] : i_pad_in[p];
            // sample leaves the functional path untouched
            assign o_pad.out[p] = (extest || intest)
                ? upd_q[B+CELL_OUT_OFS] : i_core.out[p];
            assign o_pad.oe[p] = (extest || intest)
                ? upd_q[B+CELL_OE_OFS] : i_core.oe[p];
        end
    end

    // ********************************************************
    // data registers
    // ********************************************************
    logic [ID_W-1:0] id_q;
    logic [ID_W-1:0] id_d;
    logic byp_q;
    logic byp_d;
    logic dr_bound;

    assign dr_bound = extest || intest || (mode == BST_SAMPLE);

    always_comb begin
        chain_d = chain_q;
        upd_d = upd_q;
        id_d = id_q;
        byp_d = byp_q;
        if (tck_rise && state == ST_CAP_DR) begin
            if (dr_bound) begin
                chain_d = cap_val;
            end
            id_d = {ID_VERSION, ID_DEVICE, ID_MAKER, ID_LSB};
            byp_d = BYP_CAPTURE;
        end else if (tck_rise && state == ST_SH_DR) begin
            if (dr_bound) begin
                chain_d = {chain_q[NUM_CELLS-2:0], tap_s2_q.tdi};
            end
            id_d = {tap_s2_q.tdi, id_q[ID_W-1:1]};
            byp_d = tap_s2_q.tdi;
        end
        if (tck_fall && state == ST_UPD_DR && dr_bound) begin
            upd_d = chain_q;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            chain_q <= {NUM_CELLS{CELL_RST}};
            upd_q <= {NUM_CELLS{CELL_RST}};
            id_q <= '0;
            byp_q <= BYP_CAPTURE;
        end else begin
            chain_q <= chain_d;
            upd_q <= upd_d;
            id_q <= id_d;
            byp_q <= byp_d;
        end
    end

    // ********************************************************
    // serial output, changed on falling test clock
    // ********************************************************
    logic tdo_q;
    logic tdo_d;
    logic tdo_oe_q;
    logic tdo_oe_d;

    always_comb begin
        tdo_d = tdo_q;
        tdo_oe_d = tdo_oe_q;
        if (tck_fall) begin
            tdo_oe_d = (state == ST_SH_IR) || (state == ST_SH_DR);
            if (state == ST_SH_IR) begin
                tdo_d = irsh_q[0];
            end else if (mode == BST_IDCODE) begin
                tdo_d = id_q[0];
            end else if (mode == BST_BYPASS) begin
                tdo_d = byp_q;
            end else begin
                tdo_d = chain_q[NUM_CELLS-1];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign o_tdo = tdo_q;
    assign o_tdo_oe = tdo_oe_q;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    AST_RESET_LOADS_IDCODE:
        assert property (state == ST_RESET |=> ir_q == IR_RESET_VAL)
        else $error("test-logic-reset did not load idcode");
    AST_CAPTURE_IR_VALUE:
        assert property (tck_rise && state == ST_CAP_IR |=> irsh_q == 3'h1)
        else $error("capture-ir did not load 001");
    AST_UNKNOWN_IS_BYPASS:
        assert property (ir_q inside {3'h4, 3'h5, 3'h6} |-> mode == BST_BYPASS)
        else $error("unlisted code not treated as bypass");
    AST_CHAIN_SHIFT:
        assert property (tck_rise && state == ST_SH_DR && dr_bound |=>
            chain_q[0] == $past(tap_s2_q.tdi) &&
            chain_q[NUM_CELLS-1] == $past(chain_q[NUM_CELLS-2]))
        else $error("boundary chain did not shift one place");
    AST_BYPASS_ONE_STAGE:
        assert property (tck_fall && state != ST_SH_IR &&
            mode == BST_BYPASS |=> o_tdo == $past(byp_q))
        else $error("bypass bit not presented after one stage");
    AST_ID_LSB_ONE:
        assert property (tck_rise && state == ST_CAP_DR |=> id_q[0] == 1'b1)
        else $error("identification lsb not one");
    AST_TDO_ON_FALL:
        assert property (!tck_fall |=> $stable(o_tdo) && $stable(o_tdo_oe))
        else $error("serial output moved without a falling test clock");
    AST_EXTEST_HOLDS_OUT:
        assert property (extest && !(tck_fall && state == ST_UPD_DR) &&
            !(state == ST_RESET) |=> extest |-> $stable(o_pad))
        else $error("extest outputs changed outside update");
    AST_SAMPLE_TRANSPARENT:
        assert property (mode == BST_SAMPLE |->
            o_pad.out == (i_core.out & ~IN_ONLY_MASK) &&
            o_pad.oe == (i_core.oe & ~IN_ONLY_MASK))
        else $error("sample disturbed functional outputs");
    AST_CELLS_START_ZERO:
        assert property ($rose(i_rst_n) |-> chain_q == '0 && upd_q == '0)
        else $error("boundary cells not zero after reset");

endmodule

// file: bst_host.sv
// test controller model that drives the serial test port
`timescale 1ns/1ps
module bst_host
    import bst_pkg::*;
(
    // clock
    input wire logic i_clock,
    // serial test port
    output bst_tap_s o_tap,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    initial o_tap = '0;

    task automatic half(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // one test clock; tdo is read just before the rise, and tdi is
    // scrambled after the rise so a late sample cannot pass by luck
    task automatic step(input logic ms, input logic di, output logic q,
                        output logic en);
        o_tap.tms = ms;
        o_tap.tdi = di;
        half(4);
        q = i_tdo;
        en = i_tdo_oe;
        o_tap.tck = 1'b1;
        half(2);
        o_tap.tdi = ~di;
        half(2);
        o_tap.tck = 1'b0;
    endtask

    // mode-select pattern, bit 0 first
    task automatic walk(input int n, input logic [7:0] ms);
        logic q;
        logic en;
        for (int i = 0; i < n; i++) begin
            step(ms[i], 1'b0, q, en);
        end
    endtask

    // n ones then a zero: reset (n >= 5) and on to idle
    task automatic reset_tap(input int n);
        walk(n + 1, 8'hff >> (8 - n));
    endtask

    task automatic scan_ir(input logic [2:0] code, output logic [2:0] cap);
        logic en;
        walk(4, 8'h03);
        for (int i = 0; i < 3; i++) begin
            step(i == 2, code[i], cap[i], en);
        end
        walk(2, 8'h01);
    endtask

    // capture, exit and update with no shift
    task automatic cap_ir();
        walk(6, 8'h1b);
    endtask

    task automatic scan_dr(input logic [343:0] din,
                           output logic [343:0] dout, output logic oe);
        logic en;
        oe = 1'b1;
        walk(3, 8'h01);
        for (int i = 0; i < 344; i++) begin
            step(i == 343, din[i], dout[i], en);
            oe &= en;
        end
        walk(2, 8'h01);
    endtask
endmodule

// file: testbench.sv
// self-checking bench of the boundary scan test unit
`timescale 1ns/1ps
module testbench;
    import bst_pkg::*;
    localparam logic [3:0] VER = 4'h9; // arbitrary value
    localparam logic [15:0] DEV = 16'h5a3c; // arbitrary value
    localparam logic [10:0] MKR = 11'h2b7; // arbitrary value
    localparam int CAP = 60000;
    logic i_clock;
    logic i_rst_n;
    logic o_tdo;
    logic o_tdo_oe;
    bst_tap_s tap;
    logic [NUM_PINS-1:0] i_pad_in;
    logic [NUM_PINS-1:0] o_core_in;
    bst_drive_s o_pad;
    bst_drive_s i_core;
    logic [15:0] seed;
    logic [343:0] din;
    logic [343:0] dout;
    logic [343:0] upd;
    logic [343:0] vec;
    logic [2:0] irc;
    logic [2:0] order [9] = '{3'h0, 3'h2, 3'h0, 3'h1, 3'h7, 3'h4, 3'h5,
                              3'h6, 3'h3};
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    bst_tap_unit #(.ID_VERSION(VER), .ID_DEVICE(DEV), .ID_MAKER(MKR)) dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_tap(tap), .o_tdo(o_tdo),
        .o_tdo_oe(o_tdo_oe), .i_pad_in(i_pad_in), .o_pad(o_pad),
        .i_core(i_core), .o_core_in(o_core_in));
    bst_host host (.i_clock(i_clock), .o_tap(tap), .i_tdo(o_tdo),
        .i_tdo_oe(o_tdo_oe));

    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // **********
    // expectations
    // **********
    function automatic logic [15:0] rnd();
        seed = seed[0] ? (seed >> 1) ^ 16'hb400 : seed >> 1;
        return seed;
    endfunction

    function automatic logic [343:0] rvec();
        logic [351:0] v;
        for (int i = 0; i < 22; i++) begin
            v[i*16 +: 16] = rnd();
        end
        return v[343:0];
    endfunction

    function automatic bit one(input int p);
        return p inside {17, 18, 87, 93, 94, 98, 107, 108, 117, 118,
                         [121:124]};
    endfunction

    // one-cell input positions never drive their pad
    function automatic logic [123:0] drv_mask();
        logic [123:0] m;
        for (int p = 0; p < 124; p++) begin
            m[p] = !one(p + 1);
        end
        return m;
    endfunction

    // chain cells counted from the serial input side
    function automatic logic [343:0] pack(input logic [123:0] ci, co, ce);
        logic [343:0] ch;
        int c;
        ch = '0;
        c = 0;
        for (int p = 0; p < 124; p++) begin
            ch[c] = ci[p];
            if (!one(p + 1)) begin
                ch[c+1] = co[p];
                ch[c+2] = ce[p];
            end
            c += one(p + 1) ? 1 : 3;
        end
        return ch;
    endfunction

    function automatic void unpack(input logic [343:0] ch,
                                   output logic [123:0] ci, co, ce);
        int c;
        c = 0;
        for (int p = 0; p < 124; p++) begin
            ci[p] = ch[c];
            co[p] = one(p + 1) ? 1'b0 : ch[c+1];
            ce[p] = one(p + 1) ? 1'b0 : ch[c+2];
            c += one(p + 1) ? 1 : 3;
        end
    endfunction

    // **********
    // comparisons
    // **********
    task automatic chk_bits(input string what, input logic [343:0] e,
                            input logic [343:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic chk_pins(input string what, input logic [123:0] e,
                            input logic [123:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic chk_ir(input string what, input logic [2:0] e,
                          input logic [2:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    // **********
    // scenarios
    // **********
    task automatic pins(input logic [2:0] code);
        logic [123:0] ci, co, ce;
        repeat (2) @(posedge i_clock);
        #1;
        unpack(upd, ci, co, ce);
        if (code <= 3'h1) begin
            chk_pins("pad drive", co, o_pad.out);
            chk_pins("pad enable", ce, o_pad.oe);
        end else begin
            chk_pins("pad drive", i_core.out & drv_mask(), o_pad.out);
            chk_pins("pad enable", i_core.oe & drv_mask(), o_pad.oe);
        end
        chk_pins("core in", code == 3'h1 ? ci : i_pad_in,
                 o_core_in);
    endtask

    task automatic dr_round(input logic [2:0] code);
        logic [123:0] ci, co, ce;
        logic [343:0] e;
        logic oe;
        din = rvec();
        unpack(upd, ci, co, ce);
        if (code >= 3'h4) e = {din[342:0], 1'b0};
        else if (code == 3'h3) e = {din[311:0], VER, DEV, MKR, 1'b1};
        else e = {<<{pack(code == 3'h1 ? ci : i_pad_in, i_core.out,
                          i_core.oe)}};
        host.scan_dr(din, dout, oe);
        chk_bits("scan out", e, dout);
        chk_ir("shift enable", 3'h1, {2'b0, oe});
        if (code <= 3'h2) upd = {<<{din}};
    endtask

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == CAP) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        i_rst_n = 1'b0;
        i_pad_in = '0;
        i_core = '0;
        upd = '0;
        seed = 16'ha806;
        repeat (4) @(posedge i_clock);
        #1;
        i_rst_n = 1'b1;
        repeat (4) @(posedge i_clock);
        #1;
        host.reset_tap(0);
        pins(3'h3);
        dr_round(3'h3);
        foreach (order[k]) begin
            vec = rvec();
            i_pad_in = vec[123:0];
            vec = rvec();
            i_core = vec[247:0];
            host.scan_ir(order[k], irc);
            chk_ir("ir capture", 3'h1, irc);
            pins(order[k]);
            dr_round(order[k]);
            pins(order[k]);
        end
        host.cap_ir();
        pins(3'h1);
        dr_round(3'h1);
        pins(3'h1);
        host.reset_tap(5);
        pins(3'h3);
        dr_round(3'h3);
        wrap_up();
    end
endmodule
